/* File: gdpc_pkg.sv */
// Constants shared by the gate driver pin control block
package gdpc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 20;
    // Internal reset stretch after power-up or pin reset, least time
    localparam int unsigned INIT_TIME_NS  = 1000;
    localparam int unsigned INIT_CYCLES   = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Dead time added after the monitor input falls, least time
    localparam int unsigned DEAD_TIME_NS  = 500;
    localparam int unsigned DEAD_CYCLES   = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W         = 8;

    // Register byte addresses
    localparam logic [3:0] STATUS_ADDR = 4'h0;
    localparam logic [3:0] CLEAR_ADDR  = 4'h4;
    localparam logic [3:0] CTRL_ADDR   = 4'h8;

    // Status and control fields
    localparam int unsigned ST_FAULT_A   = 0;
    localparam int unsigned ST_FAULT_B   = 1;
    localparam int unsigned ST_STP_ERR   = 2;
    localparam int unsigned ST_SUPPLY_N  = 3;
    localparam int unsigned ST_DEBUG     = 4;
    localparam int unsigned ST_ENABLE    = 5;
    localparam int unsigned ST_TURN_ON   = 6;
    localparam int unsigned ST_INHIBIT   = 7;
    localparam int unsigned ST_SELECTED  = 8;
    localparam int unsigned ST_OSD       = 9;
    localparam int unsigned CTRL_CLAMP_DIS = 0;
    localparam logic [7:0] CTRL_RESET    = 8'h00;

    // Synchroniser lanes and their idle levels
    localparam int unsigned SY_PWM    = 0;
    localparam int unsigned SY_STP    = 1;
    localparam int unsigned SY_EN     = 2;
    localparam int unsigned SY_OSD    = 3;
    localparam int unsigned SY_RSTPIN = 4;
    localparam int unsigned SY_STRAP  = 5;
    localparam int unsigned SY_GATELO = 6;
    localparam int unsigned SY_UV     = 7;
    localparam int unsigned SY_DIGINV = 8;
    localparam int unsigned SY_NUVPIN = 9;
    localparam int unsigned SY_SEL    = 10;
    localparam int unsigned SY_W      = 11;
    localparam logic [10:0] SY_RESET  = 11'h610;

    typedef enum logic [2:0] {
        GDPC_INIT  = 3'b001,
        GDPC_RUN   = 3'b010,
        GDPC_PINRST = 3'b100
    } gdpc_state_t;
endpackage : gdpc_pkg

/* File: gdpc_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module gdpc_sync #(
    parameter int unsigned     WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             srst,
    // Pins and clean levels
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, q_ff;
    logic [WIDTH-1:0] nxt_q;

    // Only stages two and three are compared; stage one may be metastable
    always_comb begin
        nxt_q = q_ff;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
                nxt_q[i] = s3_ff[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
            q_ff  <= RST_VAL;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff  <= nxt_q;
        end
    end

    assign level_out = q_ff;
endmodule : gdpc_sync

/* File: gdpc_pin_ctrl.sv */
// Pin control and notification logic of the isolated gate driver
`timescale 1ns/1ps
module gdpc_pin_ctrl (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // Avalon-MM register slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Primary side inputs
    input  wire logic        pwm_in,
    input  wire logic        shoot_through_monitor_in,
    input  wire logic        enable_in,
    input  wire logic        serial_select_n,
    // Primary side open-drain outputs
    input  wire logic        reset_ready_n_in,
    output logic             reset_ready_n_out,
    output logic             reset_ready_n_oe,
    output logic             fault_class_one_n_out,
    output logic             fault_class_one_n_oe,
    output logic             fault_class_two_n_out,
    output logic             fault_class_two_n_oe,
    // Internal event sources, same clock
    input  wire logic        event_class_one,
    input  wire logic        event_class_two,
    // Secondary side inputs
    input  wire logic        output_stage_disable,
    input  wire logic        debug_strap_in,
    input  wire logic        gate_below_threshold_in,
    input  wire logic        secondary_undervoltage_in,
    input  wire logic        digital_supply_invalid_in,
    input  wire logic        secondary_supply_invalid_n_in,
    // Secondary side outputs
    output logic             secondary_supply_invalid_n_out,
    output logic             secondary_supply_invalid_n_oe,
    output logic             turn_on_out,
    output logic             turn_on_oe,
    output logic             turn_off_out,
    output logic             turn_off_oe,
    output logic             miller_clamp_enable_out,
    output logic             booster_clamp_disable_out,
    // Mode indications
    output logic             debug_mode,
    output logic             serial_active
);
    logic [gdpc_pkg::SY_W-1:0] pins, lvl;
    logic pwm_s, stp_s, en_s, osd_s, rstpin_n_s, gatelo_s, sel_n_s;

    assign pins[gdpc_pkg::SY_PWM]    = pwm_in;
    assign pins[gdpc_pkg::SY_STP]    = shoot_through_monitor_in;
    assign pins[gdpc_pkg::SY_EN]     = enable_in;
    assign pins[gdpc_pkg::SY_OSD]    = output_stage_disable;
    assign pins[gdpc_pkg::SY_RSTPIN] = reset_ready_n_in;
    assign pins[gdpc_pkg::SY_STRAP]  = debug_strap_in;
    assign pins[gdpc_pkg::SY_GATELO] = gate_below_threshold_in;
    assign pins[gdpc_pkg::SY_UV]     = secondary_undervoltage_in;
    assign pins[gdpc_pkg::SY_DIGINV] = digital_supply_invalid_in;
    assign pins[gdpc_pkg::SY_NUVPIN] = secondary_supply_invalid_n_in;
    assign pins[gdpc_pkg::SY_SEL]    = serial_select_n;

    // Idle levels match the pad pulls so a floating pin reads safe
    gdpc_sync #(
        .WIDTH   (gdpc_pkg::SY_W),
        .RST_VAL (gdpc_pkg::SY_RESET)
    ) u_sync (
        .clock     (clock),
        .srst      (srst),
        .pin_in    (pins),
        .level_out (lvl)
    );

    assign pwm_s      = lvl[gdpc_pkg::SY_PWM];
    assign stp_s      = lvl[gdpc_pkg::SY_STP];
    assign en_s       = lvl[gdpc_pkg::SY_EN];
    assign osd_s      = lvl[gdpc_pkg::SY_OSD];
    assign rstpin_n_s = lvl[gdpc_pkg::SY_RSTPIN];
    assign gatelo_s   = lvl[gdpc_pkg::SY_GATELO];
    assign sel_n_s    = lvl[gdpc_pkg::SY_SEL];

    // Sequencer: power-up and pin reset both run the init stretch
    gdpc_pkg::gdpc_state_t state_ff, nxt_state;
    logic [gdpc_pkg::CNT_W-1:0] init_cnt_ff, nxt_init_cnt;
    logic ready, reset_event;

    always_comb begin
        nxt_state    = state_ff;
        nxt_init_cnt = init_cnt_ff;
        reset_event  = 1'b0;
        case (state_ff)
            gdpc_pkg::GDPC_INIT: begin
                // Our own pull hides the pin here, so it is not watched
                if (init_cnt_ff == gdpc_pkg::CNT_W'(gdpc_pkg::INIT_CYCLES - 1)) begin
                    nxt_state    = gdpc_pkg::GDPC_RUN;
                    nxt_init_cnt = '0;
                    reset_event  = 1'b1;
                end else begin
                    nxt_init_cnt = init_cnt_ff + 1'b1;
                end
            end
            gdpc_pkg::GDPC_RUN: begin
                // Armed only once the released pin has read high again
                if (rstpin_n_s) begin
                    nxt_init_cnt = gdpc_pkg::CNT_W'(1);
                end else if (init_cnt_ff != '0) begin
                    nxt_state = gdpc_pkg::GDPC_PINRST;
                end
            end
            gdpc_pkg::GDPC_PINRST: begin
                nxt_init_cnt = '0;
                if (rstpin_n_s) begin
                    nxt_state = gdpc_pkg::GDPC_INIT;
                end
            end
            default: begin
                nxt_state    = gdpc_pkg::GDPC_INIT;
                nxt_init_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_ff    <= gdpc_pkg::GDPC_INIT;
            init_cnt_ff <= '0;
        end else begin
            state_ff    <= nxt_state;
            init_cnt_ff <= nxt_init_cnt;
        end
    end

    assign ready = (state_ff == gdpc_pkg::GDPC_RUN);

    // Strap capture once after power-up; pin reset does not recapture
    logic strap_ff, strap_taken_ff, strap_wait_ff;
    logic nxt_strap, nxt_strap_taken, nxt_strap_wait;

    always_comb begin
        nxt_strap       = strap_ff;
        nxt_strap_taken = strap_taken_ff;
        nxt_strap_wait  = 1'b1;
        // Taken at end of init, long after the filter has settled
        if (!strap_taken_ff && strap_wait_ff && reset_event) begin
            nxt_strap       = lvl[gdpc_pkg::SY_STRAP];
            nxt_strap_taken = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            strap_ff       <= 1'b0;
            strap_taken_ff <= 1'b0;
            strap_wait_ff  <= 1'b0;
        end else begin
            strap_ff       <= nxt_strap;
            strap_taken_ff <= nxt_strap_taken;
            strap_wait_ff  <= nxt_strap_wait;
        end
    end

    assign debug_mode    = strap_ff;
    assign serial_active = !strap_ff && !sel_n_s && ready;

    // PWM input stage with shoot-through inhibition
    logic on_ff, blocked_ff, stp_err_pulse;
    logic [gdpc_pkg::CNT_W-1:0] dead_cnt_ff, nxt_dead_cnt;
    logic nxt_on, nxt_blocked, inhibit;

    assign inhibit = stp_s || (dead_cnt_ff != '0);

    always_comb begin
        nxt_dead_cnt  = dead_cnt_ff;
        nxt_blocked   = blocked_ff;
        stp_err_pulse = 1'b0;
        if (stp_s) begin
            nxt_dead_cnt = gdpc_pkg::CNT_W'(gdpc_pkg::DEAD_CYCLES);
        end else if (dead_cnt_ff != '0) begin
            nxt_dead_cnt = dead_cnt_ff - 1'b1;
        end
        // A rising edge seen while inhibited stays refused until PWM drops
        if (!pwm_s) begin
            nxt_blocked = 1'b0;
        end else if (!on_ff && inhibit && !blocked_ff && en_s && ready) begin
            nxt_blocked   = 1'b1;
            stp_err_pulse = 1'b1;
        end
        // Already-on output is held, not forced off, by inhibition
        nxt_on = ready && en_s && pwm_s
                 && (on_ff || (!inhibit && !blocked_ff));
    end

    always_ff @(posedge clock) begin
        if (srst || !ready) begin
            on_ff       <= 1'b0;
            blocked_ff  <= 1'b0;
            dead_cnt_ff <= '0;
        end else begin
            on_ff       <= nxt_on;
            blocked_ff  <= nxt_blocked;
            dead_cnt_ff <= nxt_dead_cnt;
        end
    end

    // Sticky fault flags; a new event wins over a clear in the same cycle
    logic flag_a_ff, flag_b_ff, stp_flag_ff;
    logic nxt_flag_a, nxt_flag_b, nxt_stp_flag;
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic wr_take, rd_take, ack_ff, nxt_ack;
    logic [31:0] rdata_ff, nxt_rdata, status_word;
    logic [2:0] clr_bits;

    assign wr_take  = avs_write && ack_ff;
    assign rd_take  = avs_read && !ack_ff;
    assign clr_bits = (wr_take && avs_address == gdpc_pkg::CLEAR_ADDR && avs_byteenable[0])
                      ? avs_writedata[2:0] : 3'h0;

    always_comb begin
        nxt_flag_a   = (flag_a_ff && !clr_bits[gdpc_pkg::ST_FAULT_A]) || event_class_one;
        nxt_flag_b   = (flag_b_ff && !clr_bits[gdpc_pkg::ST_FAULT_B])
                       || event_class_two || reset_event;
        nxt_stp_flag = (stp_flag_ff && !clr_bits[gdpc_pkg::ST_STP_ERR]) || stp_err_pulse;
        nxt_ctrl     = ctrl_ff;
        if (wr_take && avs_address == gdpc_pkg::CTRL_ADDR && avs_byteenable[0]) begin
            nxt_ctrl = avs_writedata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (srst || (!ready && !reset_event)) begin
            flag_a_ff   <= 1'b0;
            flag_b_ff   <= 1'b0;
            stp_flag_ff <= 1'b0;
            ctrl_ff     <= gdpc_pkg::CTRL_RESET;
        end else begin
            flag_a_ff   <= nxt_flag_a;
            flag_b_ff   <= nxt_flag_b;
            stp_flag_ff <= nxt_stp_flag;
            ctrl_ff     <= nxt_ctrl;
        end
    end

    // Bus slave: waitrequest for one cycle, answer on the second
    always_comb begin
        status_word = 32'h0;
        status_word[gdpc_pkg::ST_FAULT_A]  = flag_a_ff;
        status_word[gdpc_pkg::ST_FAULT_B]  = flag_b_ff;
        status_word[gdpc_pkg::ST_STP_ERR]  = stp_flag_ff;
        status_word[gdpc_pkg::ST_SUPPLY_N] = lvl[gdpc_pkg::SY_NUVPIN];
        status_word[gdpc_pkg::ST_DEBUG]    = strap_ff;
        status_word[gdpc_pkg::ST_ENABLE]   = en_s;
        status_word[gdpc_pkg::ST_TURN_ON]  = on_ff;
        status_word[gdpc_pkg::ST_INHIBIT]  = inhibit;
        status_word[gdpc_pkg::ST_SELECTED] = serial_active;
        status_word[gdpc_pkg::ST_OSD]      = osd_s;
        nxt_ack   = (avs_read || avs_write) && !ack_ff;
        nxt_rdata = rdata_ff;
        if (rd_take) begin
            case (avs_address)
                gdpc_pkg::STATUS_ADDR: nxt_rdata = status_word;
                gdpc_pkg::CTRL_ADDR:   nxt_rdata = {24'h0, ctrl_ff};
                default:               nxt_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            ack_ff   <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
    assign avs_readdata    = rdata_ff;

    // Secondary side output registers
    logic miller_ff, clamp_dis_ff, uv_pull_ff;
    logic nxt_miller, nxt_clamp_dis, nxt_uv_pull;

    always_comb begin
        nxt_miller    = !on_ff && gatelo_s;
        nxt_clamp_dis = ctrl_ff[gdpc_pkg::CTRL_CLAMP_DIS];
        nxt_uv_pull   = lvl[gdpc_pkg::SY_UV] || lvl[gdpc_pkg::SY_DIGINV];
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            miller_ff    <= 1'b0;
            clamp_dis_ff <= 1'b0;
            uv_pull_ff   <= 1'b1;
        end else begin
            miller_ff    <= nxt_miller;
            clamp_dis_ff <= nxt_clamp_dis;
            uv_pull_ff   <= nxt_uv_pull;
        end
    end

    assign turn_on_out               = on_ff;
    assign turn_off_out              = !on_ff;
    assign turn_on_oe                = !osd_s;
    assign turn_off_oe               = !osd_s;
    assign miller_clamp_enable_out   = miller_ff;
    assign booster_clamp_disable_out = clamp_dis_ff;
    assign secondary_supply_invalid_n_out = 1'b0;
    assign secondary_supply_invalid_n_oe  = uv_pull_ff;

    // Open-drain primary pins: drive low only, never high
    assign reset_ready_n_out     = 1'b0;
    assign reset_ready_n_oe      = (state_ff == gdpc_pkg::GDPC_INIT);
    assign fault_class_one_n_out = 1'b0;
    assign fault_class_one_n_oe  = flag_a_ff || !ready;
    assign fault_class_two_n_out = 1'b0;
    assign fault_class_two_n_oe  = flag_b_ff || !ready;
endmodule : gdpc_pin_ctrl

/* File: gdpc_pin_ctrl_chk.sv */
// Concurrent assertion checker for the gate driver pin control block
`timescale 1ns/1ps
module gdpc_pin_ctrl_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Watched inputs
    input wire logic pwm_in,
    input wire logic enable_in,
    input wire logic output_stage_disable,
    input wire logic event_class_one,
    input wire logic event_class_two,
    input wire logic reset_ready_n_in,
    input wire logic gate_below_threshold_in,
    input wire logic secondary_undervoltage_in,
    // Watched outputs
    input wire logic reset_ready_n_oe,
    input wire logic fault_class_one_n_oe,
    input wire logic fault_class_two_n_oe,
    input wire logic secondary_supply_invalid_n_oe,
    input wire logic turn_on_out,
    input wire logic turn_on_oe,
    input wire logic turn_off_out,
    input wire logic turn_off_oe,
    input wire logic miller_clamp_enable_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // Cycles the ready pin has been held low since reset release
    logic [7:0] rdy_cnt_ff;
    logic [7:0] nxt_rdy_cnt;

    always_comb begin
        nxt_rdy_cnt = 8'h00;
        if (!srst && reset_ready_n_oe) begin
            nxt_rdy_cnt = (rdy_cnt_ff == 8'hff) ? rdy_cnt_ff : rdy_cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        rdy_cnt_ff <= nxt_rdy_cnt;
    end

    // Six cycles cover the three-flop synchroniser plus its filter
    sequence s_osd_high; output_stage_disable[*6]; endsequence
    sequence s_osd_low;  !output_stage_disable[*6]; endsequence
    sequence s_pin_rst;  !reset_ready_n_in[*6]; endsequence
    sequence s_gate_low; (gate_below_threshold_in && turn_off_out)[*7]; endsequence

    AST_TON_TURN_OFF_OUT_COMPL: assert property (turn_on_out != turn_off_out)
        else $error("turn-on and turn-off outputs agree");
    AST_OSD_TRISTATE: assert property (s_osd_high |-> !turn_on_oe && !turn_off_oe)
        else $error("output stage still driven while disabled");
    AST_OSD_DRIVE: assert property (s_osd_low |-> turn_on_oe && turn_off_oe)
        else $error("output stage tristate without disable");
    AST_EN_OFF: assert property (!enable_in[*6] |-> !turn_on_out)
        else $error("turn-on while enable low");
    AST_PWM_OFF: assert property (!pwm_in[*6] |-> !turn_on_out)
        else $error("turn-on while pwm low");
    AST_INIT_FAULTS: assert property (reset_ready_n_oe |-> fault_class_one_n_oe && fault_class_two_n_oe)
        else $error("fault pin released before ready");
    AST_EVT_ONE: assert property (event_class_one |=> fault_class_one_n_oe)
        else $error("class one event not on fault one pin");
    AST_EVT_TWO: assert property (event_class_two |=> fault_class_two_n_oe)
        else $error("class two event not on fault two pin");
    AST_CLAMP_OFF: assert property (turn_on_out |=> !miller_clamp_enable_out)
        else $error("miller clamp on while turned on");
    AST_CLAMP_ON: assert property (s_gate_low |-> miller_clamp_enable_out)
        else $error("miller clamp missing with gate low");
    AST_UV_PIN: assert property (secondary_undervoltage_in[*7] |-> secondary_supply_invalid_n_oe)
        else $error("supply invalid pin not pulled");
    AST_PIN_RESET: assert property (s_pin_rst |-> fault_class_one_n_oe)
        else $error("pin reset not taken");
    AST_READY_LATE: assert property ($fell(reset_ready_n_oe) |-> 32'(rdy_cnt_ff) >= gdpc_pkg::INIT_CYCLES)
        else $error("ready released too early");
endmodule : gdpc_pin_ctrl_chk

bind gdpc_pin_ctrl gdpc_pin_ctrl_chk u_gdpc_pin_ctrl_chk (.*);

/* File: gdpc_far_model.sv */
// Host pull-ups and booster gate model facing the pin control block
`timescale 1ns/1ps
module gdpc_far_model #(
    parameter int unsigned GATE_DLY = 3
) (
    // Clock
    input  wire logic clock,
    // Host side
    input  wire logic host_rst_req,
    input  wire logic reset_ready_n_oe,
    input  wire logic fault_class_one_n_oe,
    input  wire logic fault_class_two_n_oe,
    output logic      reset_ready_n_in,
    output logic      fault_one_pin,
    output logic      fault_two_pin,
    // Booster side
    input  wire logic secondary_supply_invalid_n_oe,
    input  wire logic turn_on_out,
    input  wire logic turn_on_oe,
    input  wire logic turn_off_out,
    input  wire logic turn_off_oe,
    output logic      secondary_supply_invalid_n_in,
    output logic      gate_below_threshold_in
);
    logic [3:0] gate_cnt_ff = 4'h0;

    // Pull-ups hold every open-drain line high unless a party pulls
    assign reset_ready_n_in = !(reset_ready_n_oe || host_rst_req);
    assign fault_one_pin = !fault_class_one_n_oe;
    assign fault_two_pin = !fault_class_two_n_oe;
    assign secondary_supply_invalid_n_in = !secondary_supply_invalid_n_oe;

    // Gate discharges a few cycles after turn-off; holds while tristate
    always_ff @(posedge clock) begin
        if (turn_on_oe && turn_on_out) begin
            gate_cnt_ff <= 4'h0;
        end else if (turn_off_oe && turn_off_out && gate_cnt_ff != GATE_DLY[3:0]) begin
            gate_cnt_ff <= gate_cnt_ff + 4'h1;
        end
    end
    assign gate_below_threshold_in = (gate_cnt_ff == GATE_DLY[3:0]);
endmodule : gdpc_far_model

/* File: gdpc_pin_ctrl_tb_top.sv */
// Self-checking testbench of the gate driver pin control block
`timescale 1ns/1ps
module gdpc_pin_ctrl_tb_top;
    logic        clock, srst, avs_read, avs_write, avs_waitrequest, host_rst_req;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rdata;
    logic        pwm_in, shoot_through_monitor_in, enable_in, serial_select_n;
    logic        reset_ready_n_in, reset_ready_n_out, reset_ready_n_oe;
    logic        fault_class_one_n_out, fault_class_one_n_oe, fault_one_pin;
    logic        fault_class_two_n_out, fault_class_two_n_oe, fault_two_pin;
    logic        event_class_one, event_class_two, output_stage_disable, debug_strap_in;
    logic        gate_below_threshold_in, secondary_undervoltage_in, digital_supply_invalid_in;
    logic        secondary_supply_invalid_n_in, secondary_supply_invalid_n_out;
    logic        secondary_supply_invalid_n_oe, turn_on_out, turn_on_oe, turn_off_out;
    logic        turn_off_oe, miller_clamp_enable_out, booster_clamp_disable_out;
    logic        debug_mode, serial_active;
    int          err_total, tests_run;

    gdpc_pin_ctrl u_gdpc_pin_ctrl (.*);

    gdpc_far_model u_gdpc_far_model (.*);

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic finish_test;
        $display("tests %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    task automatic check(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %b expected %b", $time, got, exp);
        end
    endtask : check

    task automatic w(input int n);
        repeat (n) @(posedge clock);
    endtask : w

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge clock); while (avs_waitrequest !== 1'b0 && ++k < 20);
        check(k < 20, 1'b1);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rd_bit(input int b, input logic e);
        bus(1'b0, gdpc_pkg::STATUS_ADDR, 32'h0);
        check(rdata[b], e);
    endtask : rd_bit

    task automatic wait_rdy;
        int k;
        k = 0;
        check(fault_one_pin, 1'b0);
        while (fault_one_pin !== 1'b1 && k < 300) begin
            w(1);
            k++;
        end
        check(k >= int'(gdpc_pkg::INIT_CYCLES), 1'b1);
        check(fault_two_pin, 1'b0);
    endtask : wait_rdy

    task automatic t_bus;
        rd_bit(gdpc_pkg::ST_FAULT_B, 1'b1);
        bus(1'b1, gdpc_pkg::CLEAR_ADDR, 32'h2);
        w(2);
        check(fault_two_pin, 1'b1);
        bus(1'b0, 4'hc, 32'h0);
        check(rdata === 32'h0, 1'b1);
        bus(1'b1, gdpc_pkg::CTRL_ADDR, 32'h1);
        w(2);
        check(booster_clamp_disable_out, 1'b1);
        rd_bit(gdpc_pkg::ST_SUPPLY_N, 1'b1);
        $display("done bus");
    endtask : t_bus

    task automatic t_pwm;
        @(posedge clock);
        enable_in <= 1'b1;
        pwm_in <= 1'b1;
        w(8);
        check(turn_on_out, 1'b1);
        check(turn_off_out, 1'b0);
        rd_bit(gdpc_pkg::ST_TURN_ON, 1'b1);
        enable_in <= 1'b0;
        w(8);
        check(turn_on_out, 1'b0);
        rd_bit(gdpc_pkg::ST_ENABLE, 1'b0);
        pwm_in <= 1'b0;
        enable_in <= 1'b1;
        w(12);
        check(turn_on_out, 1'b0);
        check(miller_clamp_enable_out, 1'b1);
        $display("done pwm");
    endtask : t_pwm

    task automatic t_stp;
        @(posedge clock);
        shoot_through_monitor_in <= 1'b1;
        w(8);
        pwm_in <= 1'b1;
        w(8);
        check(turn_on_out, 1'b0);
        rd_bit(gdpc_pkg::ST_STP_ERR, 1'b1);
        rd_bit(gdpc_pkg::ST_INHIBIT, 1'b1);
        shoot_through_monitor_in <= 1'b0;
        w(40);
        check(turn_on_out, 1'b0);
        pwm_in <= 1'b0;
        w(8);
        pwm_in <= 1'b1;
        w(8);
        check(turn_on_out, 1'b1);
        shoot_through_monitor_in <= 1'b1;
        w(8);
        check(turn_on_out, 1'b1);
        shoot_through_monitor_in <= 1'b0;
        pwm_in <= 1'b0;
        w(10);
        pwm_in <= 1'b1;
        w(8);
        check(turn_on_out, 1'b0);
        pwm_in <= 1'b0;
        bus(1'b1, gdpc_pkg::CLEAR_ADDR, 32'h4);
        $display("done stp");
    endtask : t_stp

    task automatic t_pins;
        @(posedge clock);
        output_stage_disable <= 1'b1;
        w(8);
        check({turn_on_oe, turn_off_oe} === 2'b00, 1'b1);
        rd_bit(gdpc_pkg::ST_OSD, 1'b1);
        output_stage_disable <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            {event_class_two, event_class_one} <= 2'h1 << i;
            @(posedge clock);
            {event_class_two, event_class_one} <= 2'h0;
            w(2);
            check({fault_two_pin, fault_one_pin} === ~(2'h1 << i), 1'b1);
            rd_bit(i, 1'b1);
            bus(1'b1, gdpc_pkg::CLEAR_ADDR, 32'h1 << i);
            w(2);
            check(fault_two_pin & fault_one_pin, 1'b1);
        end
        secondary_undervoltage_in <= 1'b1;
        w(10);
        check(secondary_supply_invalid_n_in, 1'b0);
        rd_bit(gdpc_pkg::ST_SUPPLY_N, 1'b0);
        secondary_undervoltage_in <= 1'b0;
        digital_supply_invalid_in <= 1'b1;
        w(8);
        check(secondary_supply_invalid_n_in, 1'b0);
        digital_supply_invalid_in <= 1'b0;
        serial_select_n <= 1'b0;
        w(8);
        check(secondary_supply_invalid_n_in, 1'b1);
        check(serial_active, 1'b1);
        serial_select_n <= 1'b1;
        w(8);
        check(serial_active, 1'b0);
        $display("done pins");
    endtask : t_pins

    task automatic t_resets;
        @(posedge clock);
        debug_strap_in <= 1'b1;
        host_rst_req <= 1'b1;
        w(10);
        check(booster_clamp_disable_out, 1'b0);
        host_rst_req <= 1'b0;
        w(1);
        wait_rdy;
        check(debug_mode, 1'b0);
        srst <= 1'b1;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        w(1);
        wait_rdy;
        check(debug_mode, 1'b1);
        serial_select_n <= 1'b0;
        debug_strap_in <= 1'b0;
        w(8);
        check(serial_active, 1'b0);
        rd_bit(gdpc_pkg::ST_DEBUG, 1'b1);
        $display("done resets");
    endtask : t_resets

    initial begin
        #(20 * 20000);
        err_total++;
        $display("BAD %0t watchdog expired", $time);
        finish_test;
    end

    initial begin
        err_total = 0;
        tests_run = 0;
        srst = 1'b1;
        {avs_read, avs_write, host_rst_req, pwm_in, shoot_through_monitor_in} = 5'h00;
        {enable_in, event_class_one, event_class_two, output_stage_disable} = 4'h0;
        {debug_strap_in, secondary_undervoltage_in, digital_supply_invalid_in} = 3'h0;
        serial_select_n = 1'b1;
        avs_address = 4'h0;
        avs_byteenable = 4'hf;
        avs_writedata = 32'h0;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        w(1);
        wait_rdy;
        t_bus;
        t_pwm;
        t_stp;
        t_pins;
        t_resets;
        finish_test;
    end
endmodule : gdpc_pin_ctrl_tb_top
